//--- app_port.sv
// ATA task-file front end with protect/power-down pin and zone protection
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module app_port (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // ATA strobes and selects, raw pins; all but ata_addr_i synchronised inside by the app_sync instances
  input  wire logic         task_file_select_n_i,
  input  wire logic         control_block_select_n_i,
  input  wire logic [2:0]   ata_addr_i,
  input  wire logic         ata_rd_n_i,
  input  wire logic         ata_wr_n_i,
  input  wire logic         ata_reset_n_i,
  input  wire logic         protect_or_powerdown_pin_i,
  // ATA data bus
  input  wire logic [15:0]  ata_data_i,
  output logic [15:0]       ata_data_o,
  output logic [15:0]       ata_data_oe_o,
  output logic              word_xfer_n_o,
  output logic              ata_intrq_o,
  // Non-volatile cell for the pin function
  input  wire logic         nv_pd_fn_i,
  input  wire logic         nv_inited_i,
  output logic              nv_we_o,
  output logic              nv_pd_fn_o,
  output logic              nv_inited_o,
  // Back end
  output logic              cmd_valid_o,
  output logic [7:0]        cmd_code_o,
  output logic [31:0]       cmd_lba_o,
  output logic              cmd_abort_o,
  output logic              data_wr_o,
  input  wire logic [15:0]  data_rd_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              irq_o
);
  import app_pkg::*;
  parameter int unsigned INIT_BUSY_CYCLES = INIT_BUSY_CYC;

  function automatic logic is_destructive(input logic [7:0] c);
    is_destructive = (c == CMD_ERASE_SEC) || (c == CMD_FORMAT_TRK) ||
                     (c == CMD_WR_DMA0) || (c == CMD_WR_DMA1) || (c == CMD_WR_DMA_EXT) ||
                     (c == CMD_WR_MUL) || (c == CMD_WR_MUL_EXT) ||
                     (c == CMD_WR_SEC0) || (c == CMD_WR_SEC1) || (c == CMD_WR_SEC_EXT) ||
                     (c == CMD_WR_VERIFY);
  endfunction

  // Synchronised pins
  logic cs1_n, cs3_n, rd_n, wr_n, hrst_n, pin_n;
  app_sync u_s_cs1 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(task_file_select_n_i),     .level_o(cs1_n));
  app_sync u_s_cs3 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(control_block_select_n_i), .level_o(cs3_n));
  app_sync u_s_rd  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(ata_rd_n_i),               .level_o(rd_n));
  app_sync u_s_wr  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(ata_wr_n_i),               .level_o(wr_n));
  app_sync u_s_hr  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(ata_reset_n_i),            .level_o(hrst_n));
  // Pin is active high; inverted so the filter's reset level reads as released
  app_sync u_s_pin (.clk_i(clk_i), .rst_i(rst_i), .pin_i(!protect_or_powerdown_pin_i), .level_o(pin_n));

  // State
  app_state_e  st_q, st_d;
  logic [7:0]  status_q, error_q, feat_q, seccnt_q, lba0_q, lba1_q, lba2_q, devhead_q, devctl_q;
  logic        pd_fn_q, bit8_q, wr_n_q, nv_loaded_q;
  logic [31:0] init_cnt_q;
  logic [31:0] passwd_q, ctrl_q;
  logic [31:0] zone_q [N_ZONES];
  logic [N_EV-1:0] irq_st_q, irq_en_q;
  logic [15:0] rdata_q;

  // ATA decode
  wire cmd_sel   = !cs1_n && cs3_n;
  wire ctl_sel   = !cs3_n && cs1_n && (ata_addr_i == A_CTRL);
  wire wr_edge   = wr_n && !wr_n_q;
  wire do_write  = wr_edge;
  wire tf_wr     = do_write && cmd_sel;
  wire cmd_wr    = tf_wr && (ata_addr_i == A_CMD);
  wire data_sel  = cmd_sel && (ata_addr_i == A_DATA);
  wire srst      = do_write && ctl_sel && ata_data_i[CTL_SRST];
  wire any_reset = !hrst_n || srst;
  wire pin_asserted = !pin_n;
  wire cmd_lba_w = {4'h0, devhead_q[3:0], lba2_q, lba1_q, lba0_q} != 32'h0;

  // Zone hits: four zones, each from its start sector upward
  logic [N_ZONES-1:0] zone_ro_hit, zone_hide_hit;
  genvar gz;
  generate
    for (gz = 0; gz < N_ZONES; gz++)
    begin : g_zone
      wire in_zone = {devhead_q[3:0], lba2_q, lba1_q, lba0_q} >= {4'h0, zone_q[gz][31:8]};
      assign zone_ro_hit[gz]   = in_zone && (zone_q[gz][1:0] == ZM_RO);
      assign zone_hide_hit[gz] = in_zone && (zone_q[gz][1:0] == ZM_HIDE);
    end
  endgenerate
  wire unlocked  = ctrl_q[CF_UNLOCK] && (passwd_q == PASSWORD_DEFAULT);

  // Command classification
  wire [7:0] code = ata_data_i[7:0];
  wire wp_block  = !pd_fn_q && pin_asserted && is_destructive(code);
  wire zone_block = !unlocked && ((|zone_hide_hit) || ((|zone_ro_hit) && is_destructive(code)));
  wire accept    = cmd_wr && (st_q == ST_S_IDLE);
  wire pd_trip   = pd_fn_q && pin_asserted && (st_q == ST_S_BUSY);
  wire done      = ctrl_q[CF_DONE] && (st_q == ST_S_BUSY);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_S_INIT: if (init_cnt_q >= INIT_BUSY_CYCLES || nv_inited_i) st_d = ST_S_IDLE;
      ST_S_IDLE: if (accept && !wp_block && !zone_block && code != CMD_PIN_FUNC && code != CMD_SET_FEAT)
                   st_d = ST_S_BUSY;
      ST_S_BUSY: if (pd_trip) st_d = ST_S_PD;
                 else if (done) st_d = ST_S_IDLE;
      ST_S_PD:   st_d = ST_S_PD;
      default:   st_d = ST_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_S_INIT;
      init_cnt_q <= 32'h0;
      nv_loaded_q <= 1'b0;
    end
    else if (any_reset && st_q != ST_S_INIT)
      st_q <= ST_S_IDLE;
    else
    begin
      st_q <= st_d;
      if (st_q == ST_S_INIT)
        init_cnt_q <= init_cnt_q + 32'h1;
      nv_loaded_q <= 1'b1;
    end
  end

  // Pin function, persisted through the non-volatile cell
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pd_fn_q <= 1'b0;
    else if (!nv_loaded_q)
      pd_fn_q <= nv_pd_fn_i;
    else if (accept && code == CMD_PIN_FUNC)
      pd_fn_q <= (feat_q == FEAT_FN_PD);
  end
  // Only the pin-function command and the very first init write the cell, so no reset can overwrite the function
  assign nv_we_o     = (accept && (code == CMD_PIN_FUNC)) ||
                       (st_q == ST_S_INIT && st_d == ST_S_IDLE && !nv_inited_i);
  assign nv_pd_fn_o  = (accept && code == CMD_PIN_FUNC) ? (feat_q == FEAT_FN_PD) : pd_fn_q;
  assign nv_inited_o = 1'b1;

  // Task file registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i || any_reset)
    begin
      {feat_q, seccnt_q, lba0_q, lba1_q, lba2_q, devhead_q} <= '0;
      status_q <= ST_IDLE;
      error_q  <= ERR_NONE;
      devctl_q <= 8'h00;
      if (rst_i) bit8_q <= 1'b0;
    end
    else
    begin
      if (do_write && ctl_sel)
        devctl_q <= ata_data_i[7:0];
      if (tf_wr && st_q != ST_S_PD)
        case (ata_addr_i)
          A_FEATURE: feat_q    <= ata_data_i[7:0];
          A_SECCNT:  seccnt_q  <= ata_data_i[7:0];
          A_LBA0:    lba0_q    <= ata_data_i[7:0];
          A_LBA1:    lba1_q    <= ata_data_i[7:0];
          A_LBA2:    lba2_q    <= ata_data_i[7:0];
          A_DEVHEAD: devhead_q <= ata_data_i[7:0];
          default:   ;
        endcase
      if (accept && (wp_block || zone_block))
      begin
        status_q <= ST_REJECT;
        error_q  <= ERR_REJECT;
      end
      else if (accept && code == CMD_SET_FEAT)
      begin
        if (feat_q == FEAT_8BIT_ON)  bit8_q <= 1'b1;
        if (feat_q == FEAT_8BIT_OFF) bit8_q <= 1'b0;
        status_q <= ST_IDLE;
        error_q  <= ERR_NONE;
      end
      else if (accept)
      begin
        status_q <= (code == CMD_PIN_FUNC) ? ST_IDLE : (ST_IDLE | 8'h80);
        error_q  <= ERR_NONE;
      end
      else if (done)
        status_q <= ST_IDLE;
    end
  end

  wire [7:0] live_status = (st_q == ST_S_INIT || st_q == ST_S_BUSY) ? 8'h80 :
                           (st_q == ST_S_PD) ? 8'h00 : status_q;

  // Read mux
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 16'h0;
      wr_n_q  <= 1'b1;
    end
    else
    begin
      wr_n_q <= wr_n;
      if (ctl_sel)
        rdata_q <= {8'h00, live_status};
      else
        case (ata_addr_i)
          A_DATA:    rdata_q <= bit8_q ? {8'h00, data_rd_i[7:0]} : data_rd_i;
          A_ERROR:   rdata_q <= {8'h00, error_q};
          A_SECCNT:  rdata_q <= {8'h00, seccnt_q};
          A_LBA0:    rdata_q <= {8'h00, lba0_q};
          A_LBA1:    rdata_q <= {8'h00, lba1_q};
          A_LBA2:    rdata_q <= {8'h00, lba2_q};
          A_DEVHEAD: rdata_q <= {8'h00, devhead_q};
          default:   rdata_q <= {8'h00, live_status};
        endcase
    end
  end

  wire rd_act = !rd_n && (cmd_sel || ctl_sel);
  wire hi_oe  = rd_act && data_sel && !bit8_q;
  assign ata_data_o    = rdata_q;
  assign ata_data_oe_o = {{8{hi_oe}}, {8{rd_act}}};
  assign word_xfer_n_o = !(data_sel && !bit8_q);
  assign ata_intrq_o   = irq_st_q[EV_CMD] && !devctl_q[1];
  assign cmd_valid_o   = (st_q == ST_S_IDLE) && (st_d == ST_S_BUSY);
  assign cmd_code_o    = code;
  assign cmd_lba_o     = {4'h0, devhead_q[3:0], lba2_q, lba1_q, lba0_q};
  assign cmd_abort_o   = pd_trip;
  assign data_wr_o     = do_write && data_sel && (st_q == ST_S_BUSY);

  // Wishbone slave, one wait state
  wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge at which the master sees ack
  wire wb_wr   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (&wb_sel_i);
  wire [N_EV-1:0] ev = {accept && zone_block, pd_trip, accept && wp_block, done};
  wire [2:0] zidx = wb_adr_i[4:2];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_q   <= 32'h0;
      passwd_q <= 32'h0;
      irq_st_q <= '0;
      irq_en_q <= '0;
      for (int i = 0; i < N_ZONES; i++) zone_q[i] <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      ctrl_q[CF_DONE] <= 1'b0;
      // Set beats clear in the same cycle
      irq_st_q <= (irq_st_q & ~((wb_wr && wb_adr_i == R_IRQ_CLR) ? wb_dat_i[N_EV-1:0] : '0)) | ev;
      if (wb_wr)
        case (wb_adr_i)
          R_CONTROL: ctrl_q   <= wb_dat_i;
          R_IRQ_EN:  irq_en_q <= wb_dat_i[N_EV-1:0];
          R_PASSWD:  passwd_q <= wb_dat_i;
          default:   if (wb_adr_i >= R_ZONE0 && zidx < 3'(N_ZONES)) zone_q[zidx[1:0]] <= wb_dat_i;
        endcase
      case (wb_adr_i)
        R_STATUS:  wb_dat_o <= {20'h0, st_q, pd_fn_q, bit8_q, pin_asserted, 4'h0, live_status != 8'h80};
        R_CONTROL: wb_dat_o <= ctrl_q;
        R_IRQ_ST:  wb_dat_o <= {28'h0, irq_st_q};
        R_IRQ_EN:  wb_dat_o <= {28'h0, irq_en_q};
        default:   wb_dat_o <= (wb_adr_i >= R_ZONE0 && zidx < 3'(N_ZONES)) ? zone_q[zidx[1:0]] : 32'h0;
      endcase
    end
  end
  assign irq_o = |(irq_st_q & irq_en_q);
  wire unused_ok = cmd_lba_w;
endmodule // app_port

//--- app_pkg.sv
// Package: constants, commands and states for the ATA protect/power-down port
// What this block does
// - Protect/power-down pin has one meaning at a time, chosen by host command.
// - Chosen pin function is non-volatile; power loss and resets do not change it.
// - Write protection covers every logical address of the media.
// - Protected destructive commands finish with status 51H and error 04H.
// - Destructive: erase sector, format track, DMA/multiple/sector write, write-verify.
// - Non-destructive commands run normally while write protection is asserted.
// - In power-down function, pin asserted during a command aborts it into power-down.
// - In pin power-down the device ignores all commands until reset.
// - Software or hardware reset leaves pin power-down; host has released the pin.
// - First power-up reports busy about seven seconds, only once.
// - Data port is 16 bits by default; 8 bits after set-features enables it.
// - In 8-bit mode the upper byte of data reads is undefined.
// - Up to four zones, read-only or hidden; unconfigured zones are unprotected.
// - Destructive access inside a read-only zone, and any access inside a hidden zone, needs the customer password.
// - Factory state of the pin function is write protection.
// - Word-transfer indicator is low during 16-bit data transfers.
package app_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned INIT_BUSY_MS  = 7000;
  localparam int unsigned INIT_BUSY_CYC = INIT_BUSY_MS * (CLK_HZ / 1000);

  // ATA register addresses
  localparam logic [2:0] A_DATA    = 3'h0;
  localparam logic [2:0] A_ERROR   = 3'h1;
  localparam logic [2:0] A_FEATURE = 3'h1;
  localparam logic [2:0] A_SECCNT  = 3'h2;
  localparam logic [2:0] A_LBA0    = 3'h3;
  localparam logic [2:0] A_LBA1    = 3'h4;
  localparam logic [2:0] A_LBA2    = 3'h5;
  localparam logic [2:0] A_DEVHEAD = 3'h6;
  localparam logic [2:0] A_CMD     = 3'h7;
  localparam logic [2:0] A_CTRL    = 3'h6;

  // Status bits
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam logic [7:0] ST_IDLE    = 8'h50;
  localparam logic [7:0] ST_REJECT  = 8'h51;
  localparam logic [7:0] ERR_REJECT = 8'h04;
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam int CTL_SRST = 2;

  // Commands
  localparam logic [7:0] CMD_PIN_FUNC   = 8'h8B;
  localparam logic [7:0] CMD_SET_FEAT   = 8'hEF;
  localparam logic [7:0] CMD_ERASE_SEC  = 8'hC0;
  localparam logic [7:0] CMD_FORMAT_TRK = 8'h50;
  localparam logic [7:0] CMD_WR_DMA0    = 8'hCA;
  localparam logic [7:0] CMD_WR_DMA1    = 8'hCB;
  localparam logic [7:0] CMD_WR_DMA_EXT = 8'h35;
  localparam logic [7:0] CMD_WR_MUL     = 8'hC5;
  localparam logic [7:0] CMD_WR_MUL_EXT = 8'h39;
  localparam logic [7:0] CMD_WR_SEC0    = 8'h30;
  localparam logic [7:0] CMD_WR_SEC1    = 8'h31;
  localparam logic [7:0] CMD_WR_SEC_EXT = 8'h34;
  localparam logic [7:0] CMD_WR_VERIFY  = 8'h3C;
  // Feature codes
  localparam logic [7:0] FEAT_8BIT_ON   = 8'h01;
  localparam logic [7:0] FEAT_8BIT_OFF  = 8'h81;
  localparam logic [7:0] FEAT_FN_WP     = 8'h00;
  localparam logic [7:0] FEAT_FN_PD     = 8'h01;

  // Wishbone register map (byte addresses)
  localparam logic [7:0] R_STATUS  = 8'h00;
  localparam logic [7:0] R_CONTROL = 8'h04;
  localparam logic [7:0] R_IRQ_ST  = 8'h08;
  localparam logic [7:0] R_IRQ_EN  = 8'h0C;
  localparam logic [7:0] R_IRQ_CLR = 8'h10;
  localparam logic [7:0] R_PASSWD  = 8'h14;
  localparam logic [7:0] R_ZONE0   = 8'h20;
  localparam int unsigned N_ZONES  = 4;
  // Control register fields
  localparam int CF_DONE   = 0;
  localparam int CF_INITED = 1;
  localparam int CF_UNLOCK = 2;
  // Zone register fields: [1:0] mode, [31:8] start sector
  localparam logic [1:0] ZM_OFF  = 2'h0;
  localparam logic [1:0] ZM_RO   = 2'h1;
  localparam logic [1:0] ZM_HIDE = 2'h2;
  localparam logic [31:0] PASSWORD_DEFAULT = 32'h00000000;
  // Interrupt events
  localparam int EV_CMD = 0;
  localparam int EV_REJ = 1;
  localparam int EV_PD  = 2;
  localparam int EV_ZONE = 3;
  localparam int N_EV   = 4;

  typedef enum logic [3:0] {
    ST_S_INIT = 4'b0001,
    ST_S_IDLE = 4'b0010,
    ST_S_BUSY = 4'b0100,
    ST_S_PD   = 4'b1000
  } app_state_e;
endpackage

//--- app_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module app_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_q  <= 3'h7;
      level_o <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], pin_i};
      // Only stages two and three are looked at
      if (sync_q[1] == sync_q[2])
        level_o <= sync_q[2];
    end
  end
endmodule // app_sync

//--- app_port_checker.sv
// Concurrent checks on the port block's pins and register bus
`timescale 1ns/10ps
module app_port_checker
  import app_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Host side pins
  input wire logic        task_file_select_n_i,
  input wire logic        control_block_select_n_i,
  input wire logic [2:0]  ata_addr_i,
  input wire logic        protect_or_powerdown_pin_i,
  input wire logic [15:0] ata_data_oe_o,
  input wire logic        word_xfer_n_o,
  // Pin function cell and back end
  input wire logic        nv_pd_fn_i,
  input wire logic        cmd_valid_o,
  input wire logic [7:0]  cmd_code_o,
  input wire logic        cmd_abort_o,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire destructive = cmd_code_o inside {CMD_ERASE_SEC, CMD_FORMAT_TRK, CMD_WR_DMA0, CMD_WR_DMA1,
    CMD_WR_DMA_EXT, CMD_WR_MUL, CMD_WR_MUL_EXT, CMD_WR_SEC0, CMD_WR_SEC1, CMD_WR_SEC_EXT, CMD_WR_VERIFY};

  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // Sync latency is 3-4 cycles, so 8 settled cycles leave margin
  property p_word16; (ata_addr_i != A_DATA)[*8] |-> word_xfer_n_o; endproperty
  a_word16: assert property (p_word16) else $error("word indicator off data register");
  property p_float; (task_file_select_n_i && control_block_select_n_i)[*8] |-> ata_data_oe_o == 16'h0000; endproperty
  a_float: assert property (p_float) else $error("bus driven while deselected");
  property p_upper; |ata_data_oe_o[15:8] |-> !word_xfer_n_o && ata_addr_i == A_DATA; endproperty
  a_upper: assert property (p_upper) else $error("upper byte driven outside word read");
  property p_abort_pd; cmd_abort_o |-> nv_pd_fn_i && protect_or_powerdown_pin_i; endproperty
  a_abort_pd: assert property (p_abort_pd) else $error("abort without power-down pin");
  property p_abort_pulse; cmd_abort_o |=> !cmd_abort_o; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
  property p_wp_block; cmd_valid_o && !nv_pd_fn_i && protect_or_powerdown_pin_i |-> !destructive; endproperty
  a_wp_block: assert property (p_wp_block) else $error("destructive command passed");
endmodule // app_port_checker

bind app_port app_port_checker u_chk (.clk_i, .rst_i, .task_file_select_n_i, .control_block_select_n_i, .ata_addr_i,
  .protect_or_powerdown_pin_i, .ata_data_oe_o, .word_xfer_n_o, .nv_pd_fn_i, .cmd_valid_o, .cmd_code_o,
  .cmd_abort_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

//--- app_host_model.sv
// Host controller model driving the ATA selects, strobes and data lines
`timescale 1ns/10ps
module app_host_model #(
  parameter int HOLD = 8
) (
  // Clock
  input  wire logic        clk_i,
  // Strobes and data to device
  output logic             tsel_n_o,
  output logic             csel_n_o,
  output logic [2:0]       addr_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [15:0]      data_o,
  // Device drive
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] oe_i,
  input  wire logic        wx_n_i
);
  initial
  begin
    {tsel_n_o, csel_n_o, rd_n_o, wr_n_o} = 4'hF;
    addr_o = 3'h0;
    data_o = 16'h0000;
  end

  // Never both selects low; the invalid combination is avoided
  task automatic sel(input logic ctl, input logic [2:0] a);
    @(posedge clk_i);
    tsel_n_o <= ctl;
    csel_n_o <= !ctl;
    addr_o   <= a;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic ata_wr(input logic ctl, input logic [2:0] a, input logic [15:0] d);
    data_o <= d; // Upper lines kept at a valid level
    sel(ctl, a);
    wr_n_o <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    {tsel_n_o, csel_n_o} <= 2'h3;
  endtask

  // Undriven lines read back as the inverse of the last host value
  task automatic ata_rd(input logic ctl, input logic [2:0] a, output logic [15:0] d, output logic [15:0] oe,
                        output logic wx);
    sel(ctl, a);
    rd_n_o <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    d  = (data_i & oe_i) | (~data_o & ~oe_i);
    oe = oe_i;
    wx = wx_n_i;
    rd_n_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    {tsel_n_o, csel_n_o} <= 2'h3;
  endtask
endmodule // app_host_model

//--- ata_port_protect_powerdown_tb.sv
// Testbench for the protect/power-down port block
`timescale 1ns/10ps
module ata_port_protect_powerdown_tb;
  import app_pkg::*;
  localparam logic [7:0] DCMD [11] = '{CMD_ERASE_SEC, CMD_FORMAT_TRK, CMD_WR_DMA0, CMD_WR_DMA1, CMD_WR_DMA_EXT,
    CMD_WR_MUL, CMD_WR_MUL_EXT, CMD_WR_SEC0, CMD_WR_SEC1, CMD_WR_SEC_EXT, CMD_WR_VERIFY};
  logic clk_i = 1'b0, rst_i = 1'b1, ata_reset_n_i = 1'b1, protect_or_powerdown_pin_i = 1'b0;
  logic nv_pd_fn_i = 1'b0, nv_inited_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, last_code = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, n0, cmd_n = 32'h0, abort_n = 32'h0;
  logic [15:0] data_rd_i = 16'h5AC3, ata_data_i, ata_data_o, ata_data_oe_o, d, oe;
  logic [2:0]  ata_addr_i;
  logic task_file_select_n_i, control_block_select_n_i, ata_rd_n_i, ata_wr_n_i, wx, word_xfer_n_o, ata_intrq_o;
  logic nv_we_o, nv_pd_fn_o, nv_inited_o, cmd_valid_o, cmd_abort_o, data_wr_o, wb_ack_o, irq_o;
  logic [7:0]  cmd_code_o;
  logic [31:0] cmd_lba_o;
  int mismatches = 0, samples_checked = 0, k;

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  app_port #(.INIT_BUSY_CYCLES(20)) DUT (.clk_i, .rst_i, .task_file_select_n_i, .control_block_select_n_i,
    .ata_addr_i, .ata_rd_n_i, .ata_wr_n_i, .ata_reset_n_i, .protect_or_powerdown_pin_i, .ata_data_i, .ata_data_o,
    .ata_data_oe_o, .word_xfer_n_o, .ata_intrq_o, .nv_pd_fn_i, .nv_inited_i, .nv_we_o, .nv_pd_fn_o, .nv_inited_o,
    .cmd_valid_o, .cmd_code_o, .cmd_lba_o, .cmd_abort_o, .data_wr_o, .data_rd_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);

  app_host_model u_host (.clk_i, .tsel_n_o(task_file_select_n_i), .csel_n_o(control_block_select_n_i),
    .addr_o(ata_addr_i), .rd_n_o(ata_rd_n_i), .wr_n_o(ata_wr_n_i), .data_o(ata_data_i), .data_i(ata_data_o),
    .oe_i(ata_data_oe_o), .wx_n_i(word_xfer_n_o));

  // Non-volatile cell survives every reset, and back-end command monitor
  always @(posedge clk_i)
  begin
    if (nv_we_o)
      {nv_pd_fn_i, nv_inited_i} <= {nv_pd_fn_o, nv_inited_o};
    if (cmd_valid_o)
      {cmd_n, last_code} <= {cmd_n + 32'h1, cmd_code_o};
    if (cmd_abort_o)
      abort_n <= abort_n + 32'h1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      mismatches++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:8]), 32'h1);
    repeat (30) @(posedge clk_i);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:7]), 32'h4);
    wb(1'b1, R_IRQ_EN, 32'h2, q);
    protect_or_powerdown_pin_i <= 1'b1;
    u_host.ata_wr(1'b0, A_LBA2, 16'h00FF);
    n0 = cmd_n;
    foreach (DCMD[i])
    begin
      u_host.ata_wr(1'b0, A_CMD, {8'h00, DCMD[i]});
      u_host.ata_rd(1'b0, A_CMD, d, oe, wx);
      check(32'(d[7:0]), 32'(ST_REJECT));
      u_host.ata_rd(1'b0, A_ERROR, d, oe, wx);
      check(32'(d[7:0]), 32'(ERR_REJECT));
    end
    check(cmd_n, n0);
    u_host.ata_rd(1'b1, A_CTRL, d, oe, wx);
    check(32'(d[7:0]), 32'(ST_REJECT));
    check(32'(irq_o), 32'h1);
    wb(1'b1, R_IRQ_EN, 32'h0, q);
    check(32'(irq_o), 32'h0);
    wb(1'b1, R_IRQ_EN, 32'h2, q);
    wb(1'b0, R_IRQ_ST, 32'h0, q);
    check({q[1], 31'(irq_o)}, 32'h80000001);
    wb(1'b1, R_IRQ_CLR, 32'h2, q);
    check(32'(irq_o), 32'h0);
    u_host.ata_wr(1'b0, A_CMD, 16'h0020);
    check(cmd_n, n0 + 32'h1);
    check(32'(last_code), 32'h20);
    check(cmd_lba_o, 32'h00FF0000);
    wb(1'b1, R_CONTROL, 32'h1, q);
    protect_or_powerdown_pin_i <= 1'b0;
    u_host.ata_rd(1'b0, A_DATA, d, oe, wx);
    check(32'({wx, oe}), 32'h0000FFFF);
    check(32'(d), 32'h5AC3);
    check(32'(ata_intrq_o), 32'h1);
    u_host.ata_wr(1'b0, A_FEATURE, 16'(FEAT_8BIT_ON));
    u_host.ata_wr(1'b0, A_CMD, 16'(CMD_SET_FEAT));
    wb(1'b1, R_CONTROL, 32'h1, q);
    u_host.ata_rd(1'b0, A_DATA, d, oe, wx);
    check(32'({wx, oe}), 32'h000100FF);
    // Hidden zone from sector 0 refuses everything until unlocked
    wb(1'b1, R_ZONE0, 32'h2, q);
    u_host.ata_wr(1'b0, A_CMD, 16'h0020);
    u_host.ata_rd(1'b0, A_ERROR, d, oe, wx);
    check(32'(d[7:0]), 32'(ERR_REJECT));
    wb(1'b1, R_CONTROL, 32'h4, q);
    n0 = cmd_n;
    u_host.ata_wr(1'b0, A_CMD, 16'h0020);
    check(cmd_n, n0 + 32'h1);
    wb(1'b1, R_ZONE0, 32'h0, q);
    wb(1'b1, R_CONTROL, 32'h1, q);
    u_host.ata_wr(1'b0, A_FEATURE, 16'(FEAT_FN_PD));
    u_host.ata_wr(1'b0, A_CMD, 16'(CMD_PIN_FUNC));
    wb(1'b1, R_CONTROL, 32'h1, q);
    check(32'(nv_pd_fn_i), 32'h1);
    ata_reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    ata_reset_n_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:7]), 32'h5);
    // Power loss: no second init, function kept
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:7]), 32'h5);
    n0 = cmd_n;
    u_host.ata_wr(1'b0, A_CMD, 16'h0020);
    protect_or_powerdown_pin_i <= 1'b1;
    for (k = 0; k < 20 && abort_n == 0; k++)
      @(posedge clk_i);
    check(abort_n, 32'h1);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:8]), 32'h8);
    u_host.ata_wr(1'b0, A_CMD, 16'h0020);
    check(cmd_n, n0 + 32'h1);
    protect_or_powerdown_pin_i <= 1'b0;
    u_host.ata_wr(1'b1, A_CTRL, 16'h0004);
    u_host.ata_wr(1'b1, A_CTRL, 16'h0000);
    wb(1'b0, R_STATUS, 32'h0, q);
    check(32'(q[11:8]), 32'h2);
    wb(1'b0, 8'hFC, 32'h0, q);
    check(q, 32'h0);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
endmodule // ata_port_protect_powerdown_tb
